// ===== ccm_defines.svh
// register offsets, field positions and reset values of the capture/compare block
`ifndef CCM_DEFINES_SVH
`define CCM_DEFINES_SVH

`define CCM_ADDR_W 5
`define CCM_OFF_MODE 5'h00
`define CCM_OFF_CMP_LO 5'h04
`define CCM_OFF_CMP_HI 5'h08
`define CCM_OFF_CTRL 5'h0C
`define CCM_OFF_COUNT 5'h10

`define CCM_BIT_PWM16 7
`define CCM_BIT_CMP_EN 6
`define CCM_BIT_RISE_SEL 5
`define CCM_BIT_FALL_SEL 4
`define CCM_BIT_MATCH_EN 3
`define CCM_BIT_TOGGLE_EN 2
`define CCM_BIT_PWM 1
`define CCM_BIT_IRQ_EN 0

`define CCM_BIT_FLAG 0
`define CCM_BIT_PIN_IN 1
`define CCM_BIT_PIN_OUT 2
`define CCM_BIT_IRQ 3

`define CCM_MODE_RST 8'h00
`define CCM_CMP_RST 8'h00
`define CCM_RESP_OKAY 2'b00
`define CCM_RESP_SLVERR 2'b10

`endif

// ===== ccm_pkg.sv
// types shared by the capture/compare block modules
package ccm_pkg;
  `include "ccm_defines.svh"

  typedef logic [`CCM_ADDR_W-1:0] ccm_addr_t;
  typedef logic [31:0] ccm_word_t;
  typedef logic [3:0] ccm_strb_t;
  typedef logic [15:0] ccm_cnt_t;
  typedef logic [1:0] ccm_resp_t;

  // pin synchroniser and edge history
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ccm_edge_state_t;

  // registered compare hit
  typedef struct packed {
    logic hit;
  } ccm_match_state_t;

  // whole state of the top module
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] cmp_lo;
    logic [7:0] cmp_hi;
    logic flag;
    logic pin_out;
    logic pin_oe;
    logic irq;
    logic awready;
    logic wready;
    logic bvalid;
    ccm_resp_t bresp;
    logic aw_got;
    logic w_got;
    ccm_addr_t waddr;
    ccm_word_t wdata;
    ccm_strb_t wstrb;
    logic arready;
    logic rvalid;
    ccm_resp_t rresp;
    ccm_word_t rdata;
  } ccm_top_state_t;
endpackage

// ===== ccm_evt_if.sv
// events passed from the pin and compare helpers to the top
`timescale 1ns/1ps
interface ccm_evt_if;
  logic rise;
  logic fall;
  logic level;
  logic match;

  modport edge_src (output rise, output fall, output level);
  modport match_src (output match);
  modport sink (input rise, input fall, input level, input match);
endinterface

// ===== ccm_edge_detect.sv
// two-flop pin synchroniser with rising and falling edge detection
`timescale 1ns/1ps
module ccm_edge_detect (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // raw pin level
  input wire logic pin_in,
  // edge events
  ccm_evt_if.edge_src evt
);
  import ccm_pkg::*;

  ccm_edge_state_t r_r;
  ccm_edge_state_t r_nxt;

  // shift the pin through; s1 is read only by s2
  always_comb begin
    r_nxt = r_r;
    r_nxt.s1 = pin_in;
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // edges seen between the settled stages only
  assign evt.rise = r_r.s2 & ~r_r.s3;
  assign evt.fall = ~r_r.s2 & r_r.s3;
  assign evt.level = r_r.s2;
endmodule

// ===== ccm_match.sv
// counter against compare equality, sampled once per counter step
`timescale 1ns/1ps
module ccm_match (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // shared counter and compare value
  input wire ccm_pkg::ccm_cnt_t counter_value,
  input wire logic counter_tick,
  input wire ccm_pkg::ccm_cnt_t compare,
  // match event
  ccm_evt_if.match_src evt
);
  import ccm_pkg::*;

  ccm_match_state_t r_r;
  ccm_match_state_t r_nxt;

  // one hit per step
  // only a counter step qualifies, so a parked counter fires once
  always_comb begin
    r_nxt = r_r;
    r_nxt.hit = counter_tick && (counter_value == compare);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= '0;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign evt.match = r_r.hit;
endmodule

// ===== ccm_top.sv
// capture/compare module of the counter array with an AXI4-Lite slave
//
// What this block does
// - capture mode copies the shared counter into both compare bytes on an edge
// - rising and falling select bits pick capture edge; both give either edge
// - every capture sets the module event flag to one
// - interrupt request rises while event flag and module interrupt enable are set
// - hardware never clears the event flag; software writes it to zero
// - with both edge selects set, the pin level stays readable
// - timer mode compares counter with compare register, flags equality
// - timer mode needs comparator enable and match flag enable both set
// - low byte write clears comparator enable; high byte write sets it
// - high speed output inverts the pin on each match and flags it
// - high speed output needs toggle and comparator enable set; flagging it also needs match flag enable
// - clearing comparator enable freezes the pin at its present level unless the pwm bit is set
// - comparator off: no toggling, and the pwm bit (not pwm16) drives the pin low
// - with match flag enable set, every comparator match sets the flag
`timescale 1ns/1ps
`include "ccm_defines.svh"
module ccm_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire ccm_pkg::ccm_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire ccm_pkg::ccm_word_t s_axi_wdata,
  input wire ccm_pkg::ccm_strb_t s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output ccm_pkg::ccm_resp_t s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire ccm_pkg::ccm_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output ccm_pkg::ccm_word_t s_axi_rdata,
  output ccm_pkg::ccm_resp_t s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // shared counter of the array
  input wire ccm_pkg::ccm_cnt_t counter_value,
  input wire logic counter_tick,
  // module pin
  input wire logic module_io_pin_in,
  output logic module_io_pin_out,
  output logic module_io_pin_oe,
  // interrupt request contribution
  output logic counter_array_irq
);
  import ccm_pkg::*;

  // reset image: all bus readies up, nothing pending
  localparam ccm_top_state_t TOP_RST = '{
    mode: `CCM_MODE_RST,
    cmp_lo: `CCM_CMP_RST,
    cmp_hi: `CCM_CMP_RST,
    awready: 1'b1,
    wready: 1'b1,
    arready: 1'b1,
    bresp: `CCM_RESP_OKAY,
    rresp: `CCM_RESP_OKAY,
    default: '0
  };

  // state register and its next value
  ccm_top_state_t r_r;
  ccm_top_state_t r_nxt;
  // event bundle filled by the two helpers
  ccm_evt_if evt ();

  // helper signals of the next-state logic
  logic cap_evt;
  logic cmp_evt;
  logic wr_strobe;
  logic sel_rise;
  logic sel_fall;
  logic cmp_on;
  logic match_on;
  logic toggle_on;
  ccm_word_t rd_mux;
  ccm_resp_t rd_resp;

  // pin edges and level, synchronised inside
  ccm_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_in(module_io_pin_in),
    .evt(evt.edge_src)
  );

  // comparator against the registered compare value
  ccm_match u_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .counter_value(counter_value),
    .counter_tick(counter_tick),
    .compare({r_r.cmp_hi, r_r.cmp_lo}),
    .evt(evt.match_src)
  );

  // mode bits as they stand this cycle
  assign sel_rise = r_r.mode[`CCM_BIT_RISE_SEL];
  assign sel_fall = r_r.mode[`CCM_BIT_FALL_SEL];
  assign cmp_on = r_r.mode[`CCM_BIT_CMP_EN];
  assign match_on = r_r.mode[`CCM_BIT_MATCH_EN];
  assign toggle_on = r_r.mode[`CCM_BIT_TOGGLE_EN];

  // edge select
  // either select alone picks one edge, both together pick either edge
  assign cap_evt = (sel_rise & evt.rise) | (sel_fall & evt.fall);

  // comparator gate
  // a disabled comparator yields no match events at all
  assign cmp_evt = evt.match & cmp_on;

  // read mux, decoded from the live read address
  always_comb begin
    rd_mux = '0;
    rd_resp = `CCM_RESP_OKAY;
    case (s_axi_araddr)
      `CCM_OFF_MODE: begin
        rd_mux[7:0] = r_r.mode;
      end
      `CCM_OFF_CMP_LO: begin
        rd_mux[7:0] = r_r.cmp_lo;
      end
      `CCM_OFF_CMP_HI: begin
        rd_mux[7:0] = r_r.cmp_hi;
      end
      `CCM_OFF_CTRL: begin
        rd_mux[`CCM_BIT_FLAG] = r_r.flag;
        // pin level
        // lets software tell a rising from a falling capture
        rd_mux[`CCM_BIT_PIN_IN] = evt.level;
        rd_mux[`CCM_BIT_PIN_OUT] = r_r.pin_out;
        rd_mux[`CCM_BIT_IRQ] = r_r.irq;
      end
      `CCM_OFF_COUNT: begin
        // live count, never latched
        rd_mux[15:0] = counter_value;
      end
      default: begin
        // unmapped offsets read as zero with an error
        rd_resp = `CCM_RESP_SLVERR;
      end
    endcase
  end

  // all next-state logic of the top module
  always_comb begin
    // hold everything unless a rule below moves it
    r_nxt = r_r;
    wr_strobe = 1'b0;

    // address and data may arrive in either order
    if (s_axi_awvalid && r_r.awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.waddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end

    // both halves present: perform the write
    if (r_nxt.aw_got && r_nxt.w_got && !r_r.bvalid) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp = `CCM_RESP_OKAY;
      // only the low byte lane carries register bits
      wr_strobe = r_nxt.wstrb[0];
      case (r_nxt.waddr)
        `CCM_OFF_MODE: begin
          if (wr_strobe) begin
            // whole byte, comparator enable included
            r_nxt.mode = r_nxt.wdata[7:0];
          end
        end
        `CCM_OFF_CMP_LO: begin
          if (wr_strobe) begin
            r_nxt.cmp_lo = r_nxt.wdata[7:0];
            // low write disarms
            // stops a half-loaded compare value from matching
            r_nxt.mode[`CCM_BIT_CMP_EN] = 1'b0;
          end
        end
        `CCM_OFF_CMP_HI: begin
          if (wr_strobe) begin
            r_nxt.cmp_hi = r_nxt.wdata[7:0];
            r_nxt.mode[`CCM_BIT_CMP_EN] = 1'b1;
          end
        end
        `CCM_OFF_CTRL: begin
          // software clear
          // the only path that ever lowers the flag
          if (wr_strobe) begin
            r_nxt.flag = r_nxt.wdata[`CCM_BIT_FLAG];
          end
        end
        `CCM_OFF_COUNT: begin
          // counter view is read only; write accepted and dropped
        end
        default: begin
          // unmapped offsets change nothing
          r_nxt.bresp = `CCM_RESP_SLVERR;
        end
      endcase
    end

    // response handshake
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    // readies stay low until the response has gone
    r_nxt.awready = !r_nxt.aw_got && !r_nxt.bvalid;
    r_nxt.wready = !r_nxt.w_got && !r_nxt.bvalid;

    // read channel, one outstanding
    if (s_axi_arvalid && r_r.arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rdata = rd_mux;
      r_nxt.rresp = rd_resp;
    end else if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
    // no new read while read data still waits
    r_nxt.arready = !r_nxt.rvalid;

    // capture counter
    // capture beats a same-cycle software byte write
    if (cap_evt) begin
      r_nxt.cmp_lo = counter_value[7:0];
      r_nxt.cmp_hi = counter_value[15:8];
      r_nxt.flag = 1'b1;
    end

    // comparator enable plus match flag enable
    // hardware set wins over a same-cycle software clear
    if (cmp_evt && match_on) begin
      r_nxt.flag = 1'b1;
    end

    // no toggle unless comparator enable is set
    if (cmp_evt && toggle_on) begin
      r_nxt.pin_out = ~r_r.pin_out;
    end

    // pwm held low
    // with the comparator off the pwm bit parks the pin low; the pwm16 bit does not
    if (r_nxt.mode[`CCM_BIT_PWM] && !r_nxt.mode[`CCM_BIT_CMP_EN]) begin
      r_nxt.pin_out = 1'b0;
    end

    // pin driven only in the output modes
    r_nxt.pin_oe = r_nxt.mode[`CCM_BIT_TOGGLE_EN] |
                   r_nxt.mode[`CCM_BIT_PWM];

    // interrupt request
    // level follows flag and enable, so a cleared flag drops it
    r_nxt.irq = r_nxt.flag & r_nxt.mode[`CCM_BIT_IRQ_EN];
  end

  // synchronous reset loads the reset image
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r <= TOP_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // every output straight from the state register
  // write channels
  assign s_axi_awready = r_r.awready;
  assign s_axi_wready = r_r.wready;
  assign s_axi_bvalid = r_r.bvalid;
  assign s_axi_bresp = r_r.bresp;

  // read channels
  assign s_axi_arready = r_r.arready;
  assign s_axi_rvalid = r_r.rvalid;
  assign s_axi_rdata = r_r.rdata;
  assign s_axi_rresp = r_r.rresp;

  // pin and request
  assign module_io_pin_out = r_r.pin_out;
  assign module_io_pin_oe = r_r.pin_oe;
  assign counter_array_irq = r_r.irq;
endmodule

// ===== ccm_top_props.sv
// port checker of the capture/compare block
`timescale 1ns/1ps
module ccm_top_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire ccm_pkg::ccm_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire ccm_pkg::ccm_resp_t s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire ccm_pkg::ccm_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire ccm_pkg::ccm_word_t s_axi_rdata,
  input wire ccm_pkg::ccm_resp_t s_axi_rresp,
  input wire logic s_axi_rvalid,
  // counter, pin, request
  input wire logic counter_tick,
  input wire logic module_io_pin_out,
  input wire logic module_io_pin_oe,
  input wire logic counter_array_irq
);
  import ccm_pkg::*;
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_state_a: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && !module_io_pin_oe
    && !counter_array_irq) else $error("outputs not cleared by reset");
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write response late");
  wr_refuse_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready && s_axi_awaddr >= 5'h14 |=>
    s_axi_bresp == 2'b10) else $error("unmapped write accepted");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read data late");
  rd_refuse_a: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr >= 5'h14 |=> s_axi_rresp == 2'b10 && s_axi_rdata == '0)
    else $error("unmapped read accepted");
  bus_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  // a toggle shows two edges after the counter step is sampled
  pin_rise_a: assert property ($rose(module_io_pin_out) |->
    $past(counter_tick, 2)) else $error("pin rose without a match");
  // one event per counter step, never on consecutive cycles
  pin_hold_a: assert property ($changed(module_io_pin_out) |=>
    $stable(module_io_pin_out)) else $error("pin toggled twice");
endmodule
bind ccm_top ccm_top_props u_props (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .counter_tick, .module_io_pin_out, .module_io_pin_oe, .counter_array_irq);

// ===== test_counter_array_capture_compare_module.sv
// self-checking bench of the capture/compare block
`timescale 1ns/1ps
module test_counter_array_capture_compare_module;
  import ccm_pkg::*;
  typedef struct {ccm_addr_t wa; logic [7:0] wd; ccm_addr_t ra;
    ccm_word_t ex; ccm_resp_t rs;} ccm_row_t;
  logic aclk = 0, aresetn = 0;
  ccm_addr_t s_axi_awaddr = '0, s_axi_araddr = '0;
  ccm_word_t s_axi_wdata = '0, s_axi_rdata, rd_v;
  ccm_strb_t s_axi_wstrb = 4'h1;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, module_io_pin_out, module_io_pin_oe, counter_array_irq;
  ccm_resp_t s_axi_bresp, s_axi_rresp, rs;
  ccm_cnt_t counter_value = 16'h0a5c;
  logic counter_tick = 0, module_io_pin_in = 0;
  int failures = 0, comparisons = 0;
  ccm_row_t rows[7];
  always #4 aclk = ~aclk;
  // responses are always accepted at once
  ccm_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .counter_value,
    .counter_tick, .module_io_pin_in, .module_io_pin_out,
    .module_io_pin_oe, .counter_array_irq);
  task automatic chk(input ccm_word_t seen, input ccm_word_t exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // each channel released once its ready is seen
  // only the watchdog ends a wait for the answer
  task automatic wr(input ccm_addr_t a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rs = s_axi_bresp;
  endtask
  task automatic rd(input ccm_addr_t a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask
  // five counter steps around v, one tick per step
  task automatic sweep(input ccm_cnt_t v);
    for (int i = -2; i < 3; i++) begin
      counter_value <= ccm_cnt_t'(v + i);
      counter_tick <= 1'b1;
      @(posedge aclk);
      counter_tick <= 1'b0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
  endtask
  task automatic pin_to(input logic lvl, input ccm_cnt_t v);
    counter_value <= v;
    module_io_pin_in <= lvl;
    repeat (8) @(posedge aclk);
  endtask
  task automatic wrap_up;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // whole run needs under 2000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up();
  end
  initial begin
    rows[0] = '{5'h00, 8'h48, 5'h00, 32'h48, 2'b00};
    rows[1] = '{5'h04, 8'h34, 5'h00, 32'h08, 2'b00};
    rows[2] = '{5'h08, 8'h12, 5'h00, 32'h48, 2'b00};
    rows[3] = '{5'h04, 8'h34, 5'h04, 32'h34, 2'b00};
    rows[4] = '{5'h08, 8'h12, 5'h08, 32'h12, 2'b00};
    rows[5] = '{5'h10, 8'hff, 5'h10, 32'h0a5c, 2'b00};
    rows[6] = '{5'h14, 8'hff, 5'h14, 32'h0, 2'b10};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int a = 0; a < 16; a += 4) begin
      rd(ccm_addr_t'(a));
      chk(rd_v, 32'h0);
    end
    foreach (rows[i]) begin
      wr(rows[i].wa, rows[i].wd);
      chk({30'h0, rs}, {30'h0, rows[i].rs});
      rd(rows[i].ra);
      chk(rd_v, rows[i].ex);
      chk({30'h0, rs}, {30'h0, rows[i].rs});
    end
    // capture on rising edge only, interrupt enabled
    wr(5'h00, 8'h21);
    pin_to(1'b1, 16'habcd);
    rd(5'h04);
    chk(rd_v, 32'hcd);
    rd(5'h08);
    chk(rd_v, 32'hab);
    rd(5'h0c);
    chk(rd_v, 32'h0b);
    chk(counter_array_irq, 1'b1);
    pin_to(1'b0, 16'h5678);
    rd(5'h04);
    chk(rd_v, 32'hcd);
    rd(5'h0c);
    chk(rd_v, 32'h09);
    wr(5'h0c, 8'h00);
    rd(5'h0c);
    chk(rd_v, 32'h00);
    chk(counter_array_irq, 1'b0);
    // both edges: falling one captures too
    wr(5'h00, 8'h31);
    pin_to(1'b1, 16'h5678);
    pin_to(1'b0, 16'h9abc);
    rd(5'h08);
    chk(rd_v, 32'h9a);
    rd(5'h0c);
    chk(rd_v, 32'h09);
    // timer set up, low byte before high byte
    wr(5'h00, 8'h09);
    wr(5'h0c, 8'h00);
    wr(5'h04, 8'h10);
    wr(5'h08, 8'h00);
    rd(5'h00);
    chk(rd_v, 32'h49);
    sweep(16'h0010);
    rd(5'h0c);
    chk(rd_v, 32'h09);
    // comparator off after a lone low byte write
    wr(5'h0c, 8'h00);
    wr(5'h04, 8'h10);
    sweep(16'h0010);
    rd(5'h0c);
    chk(rd_v, 32'h00);
    // high speed output toggles the pin
    wr(5'h00, 8'h0c);
    wr(5'h08, 8'h00);
    sweep(16'h0010);
    chk(module_io_pin_out, 1'b1);
    chk(module_io_pin_oe, 1'b1);
    rd(5'h0c);
    chk(rd_v, 32'h05);
    wr(5'h04, 8'h10);
    sweep(16'h0010);
    chk(module_io_pin_out, 1'b1);
    wr(5'h00, 8'h02);
    repeat (2) @(posedge aclk);
    chk(module_io_pin_out, 1'b0);
    // high byte write with its lane off must not arm the comparator
    s_axi_wstrb <= 4'h0;
    wr(5'h08, 8'h77);
    s_axi_wstrb <= 4'h1;
    rd(5'h00);
    chk(rd_v, 32'h02);
    rd(5'h08);
    chk(rd_v, 32'h00);
    wrap_up();
  end
endmodule
